/* rtl/obj_addr_xlate.sv */
module obj_addr_xlate (
   // Request in
   input  wire logic              isObject,
   input  wire logic [15:0]       addrIn,
   // Register address out
   output logic [15:0]            regAddr,
   output logic                   objBad
);

   logic [7:0]  classId;
   logic [7:0]  instId;
   logic [15:0] offs;

   // Class and instance to register address
   always_comb begin
      classId  = addrIn[15:8];
      instId   = addrIn[7:0];
      offs     = {8'h00, instId - user_map_pkg::OBJ_INST_FIRST};
      regAddr  = addrIn;
      objBad   = 1'b0;
      if (isObject) begin
         objBad = (instId < user_map_pkg::OBJ_INST_FIRST)
               || (instId > user_map_pkg::OBJ_INST_LAST);
         if (classId == user_map_pkg::OBJ_CLASS_ADDR) begin
            regAddr = user_map_pkg::TABLE_BASE + offs;
         end else if (classId == user_map_pkg::OBJ_CLASS_VALUE) begin
            regAddr = user_map_pkg::VALUE_BASE + offs;
         end else begin
            objBad = 1'b1;
         end
      end
   end

endmodule : obj_addr_xlate

/* rtl/req_arbiter.sv */
module req_arbiter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Requests and grant
   input  wire logic netValid,
   input  wire logic cfgValid,
   input  wire logic take,
   output logic      grantAny,
   output logic      grantNet
);

   logic favourNet_reg;
   logic favourNet_next;

   // Alternating priority so neither party starves
   always_comb begin
      grantAny = netValid || cfgValid;
      grantNet = netValid && (favourNet_reg || !cfgValid);
      favourNet_next = favourNet_reg;
      if (take) begin
         favourNet_next = !grantNet;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         favourNet_reg <= 1'b1;
      end else begin
         favourNet_reg <= favourNet_next;
      end
   end

endmodule : req_arbiter

/* rtl/user_map_pkg.sv */
package user_map_pkg;

   // Table and value window, register addresses
   localparam int unsigned SLOT_COUNT  = 99;
   localparam logic [15:0] TABLE_BASE  = 16'h0320;
   localparam logic [15:0] TABLE_RSVD  = 16'h0383;
   localparam logic [15:0] VALUE_BASE  = 16'h0384;
   localparam logic [15:0] VALUE_RSVD  = 16'h03E7;
   localparam logic [15:0] ENTRY_RESET = 16'h0000;
   localparam logic [15:0] WORD_ZERO   = 16'h0000;

   // Fast-access alias set
   localparam logic [15:0] FAST_MIRROR = 16'h09C4;
   localparam logic [15:0] FAST_RSVD   = 16'h09C5;
   localparam logic [15:0] FAST_SYS1   = 16'h09C6;
   localparam logic [15:0] FAST_SYS2   = 16'h09C7;
   localparam logic [15:0] FAST_IN     = 16'h09C8;
   localparam logic [15:0] FAST_OUT    = 16'h09C9;
   localparam logic [15:0] FAST_OCMD   = 16'h09CA;
   localparam logic [15:0] FAST_CTRL   = 16'h09CB;
   localparam logic [15:0] FAST_AOCMD  = 16'h09CC;

   // Primary registers behind the aliases
   localparam logic [15:0] PRI_SYS1    = 16'h01C7;
   localparam logic [15:0] PRI_SYS2    = 16'h01C8;
   localparam logic [15:0] PRI_IN      = 16'h01C9;
   localparam logic [15:0] PRI_OUT     = 16'h01CA;
   localparam logic [15:0] PRI_OCMD    = 16'h02BC;
   localparam logic [15:0] PRI_CTRL    = 16'h02C0;
   localparam logic [15:0] PRI_AOCMD   = 16'h02C2;

   // Average current, most significant word first
   localparam logic [15:0] CUR_MSW     = 16'h01F4;
   localparam logic [15:0] CUR_LSW     = 16'h01F5;

   // Object addressing
   localparam logic [7:0]  OBJ_CLASS_ADDR  = 8'h6D;
   localparam logic [7:0]  OBJ_CLASS_VALUE = 8'h6E;
   localparam logic [7:0]  OBJ_INST_FIRST  = 8'h01;
   localparam logic [7:0]  OBJ_INST_LAST   = 8'h64;

   typedef struct packed {
      logic        write;
      logic        isObject;
      logic [15:0] addr;
      logic [15:0] wdata;
   } req_t;

   typedef struct packed {
      logic        valid;
      logic        exception;
      logic [15:0] rdata;
   } ans_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tgt_req_t;

   typedef struct packed {
      logic        ack;
      logic        error;
      logic [15:0] rdata;
   } tgt_ans_t;

   typedef struct packed {
      logic        hit;
      logic        legal;
      logic        fwd;
      logic [15:0] target;
   } alias_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FWD  = 2'b01,
      ST_DONE = 2'b11
   } state_t;

   // Alias decode of the fast-access profile
   function automatic alias_t alias_map(input logic [15:0] a,
                                        input logic        wr,
                                        input logic        fast);
      alias_t r;
      r = '0;
      r.hit = fast && (a >= FAST_MIRROR) && (a <= FAST_AOCMD);
      r.legal = !wr;
      r.fwd   = 1'b1;
      unique case (a)
         FAST_MIRROR, FAST_RSVD: r.fwd = 1'b0;
         FAST_SYS1: r.target = PRI_SYS1;
         FAST_SYS2: r.target = PRI_SYS2;
         FAST_IN:   r.target = PRI_IN;
         FAST_OUT:  r.target = PRI_OUT;
         FAST_OCMD: begin
            r.legal  = wr;
            r.target = PRI_OCMD;
         end
         FAST_CTRL: begin
            r.legal  = 1'b1;
            r.target = PRI_CTRL;
         end
         FAST_AOCMD: begin
            r.legal  = wr;
            r.target = PRI_AOCMD;
         end
         default: begin
            r.legal = 1'b0;
            r.fwd   = 1'b0;
         end
      endcase
      return r;
   endfunction : alias_map

endpackage : user_map_pkg

/* rtl/user_map_register_indirection.sv */
// Summary of operation
// - 99 address-table words hold target addresses; next word reserved.
// - Value slot k reaches the register named by table entry k.
// - The same one-to-one pairing holds for every following slot.
// - Table entries are stored configuration, kept until rewritten or cleared by reset.
// - Both network client and local tool may write the table.
// - Separate table ranges may serve as read areas and write areas.
// - Consecutive slot reads return each mapped target in slot order.
// - Consecutive slot writes deliver each word to its mapped target.
// - Table and values also reachable as object classes 6D and 6E.
// - Fast profile: mirror word, reserved word, then four status aliases.
// - Fast profile output command alias writes primary output command; reads raise an exception.
// - Fast profile control alias reads and writes the primary control.
// - Fast profile analog output command alias writes primary analog output command one.
// - A configuration input chooses fast alias profile or full list.
// - Average current kept as two words, most significant first.
module user_map_register_indirection #(
   parameter int unsigned SLOTS = user_map_pkg::SLOT_COUNT
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Network client port
   input  wire logic                   netValid,
   input  wire user_map_pkg::req_t     netReq,
   output user_map_pkg::ans_t          netAns,
   // Local configuration port
   input  wire logic                   cfgValid,
   input  wire user_map_pkg::req_t     cfgReq,
   output user_map_pkg::ans_t          cfgAns,
   // Target register path
   output user_map_pkg::tgt_req_t      tgtReq,
   input  wire user_map_pkg::tgt_ans_t tgtAns,
   // Profile select and local values
   input  wire logic                   fastProfile,
   input  wire logic [15:0]            mirrorStatus,
   input  wire logic [31:0]            avgCurrent
);

   if (SLOTS < 1 || SLOTS > user_map_pkg::SLOT_COUNT) begin : g_bad_slots
      $error("SLOTS must lie between 1 and 99");
   end

   localparam logic [15:0] SLOT_LAST = user_map_pkg::VALUE_BASE
                                     + 16'(SLOTS - 1);
   localparam logic [15:0] ENTRY_LAST = user_map_pkg::TABLE_BASE
                                      + 16'(SLOTS - 1);

   user_map_pkg::state_t     state_reg;
   user_map_pkg::state_t     state_next;
   logic                     servNet_reg;
   logic                     servNet_next;
   logic                     curWrite_reg;
   logic                     curWrite_next;
   user_map_pkg::ans_t       netAns_reg;
   user_map_pkg::ans_t       netAns_next;
   user_map_pkg::ans_t       cfgAns_reg;
   user_map_pkg::ans_t       cfgAns_next;
   user_map_pkg::tgt_req_t   tgtReq_reg;
   user_map_pkg::tgt_req_t   tgtReq_next;
   logic [15:0]              lswHold_reg;
   logic [15:0]              lswHold_next;
   logic [15:0]              table_reg [SLOTS];

   logic                     grantAny;
   logic                     grantNet;
   logic                     take;
   user_map_pkg::req_t       selReq;
   logic [15:0]              regAddr;
   logic                     objBad;
   logic [15:0]              slotOff;
   logic [6:0]               slotIdx;
   logic [15:0]              slotEntry;
   logic                     viaSlot;
   logic [15:0]              effAddr;
   user_map_pkg::alias_t     aliasHit;
   logic                     tableWe;
   logic [6:0]               tableIdx;
   logic [15:0]              ansWord;
   logic                     ansExc;
   logic                     ansFire;
   logic                     goFwd;
   logic [15:0]              fwdAddr;
   logic [15:0]              curMsw;

   assign take   = (state_reg == user_map_pkg::ST_IDLE) && grantAny;
   assign selReq = grantNet ? netReq : cfgReq;
   assign curMsw = avgCurrent[31:16];

   req_arbiter u_arbiter (
      .clk      (clk),
      .rst      (rst),
      .netValid (netValid),
      .cfgValid (cfgValid),
      .take     (take),
      .grantAny (grantAny),
      .grantNet (grantNet)
   );

   obj_addr_xlate u_xlate (
      .isObject (selReq.isObject),
      .addrIn   (selReq.addr),
      .regAddr  (regAddr),
      .objBad   (objBad)
   );

   // Address decode of the taken request
   always_comb begin
      slotOff   = regAddr - user_map_pkg::VALUE_BASE;
      slotIdx   = slotOff[6:0];
      tableIdx  = 7'(regAddr - user_map_pkg::TABLE_BASE);
      slotEntry = user_map_pkg::ENTRY_RESET;
      viaSlot   = (regAddr >= user_map_pkg::VALUE_BASE)
               && (regAddr <= SLOT_LAST);
      if (viaSlot) begin
         slotEntry = table_reg[slotIdx];
      end
      effAddr  = viaSlot ? slotEntry : regAddr;
      aliasHit = user_map_pkg::alias_map(effAddr, selReq.write,
                                         fastProfile);
      tableWe  = 1'b0;
      ansWord  = user_map_pkg::WORD_ZERO;
      ansExc   = 1'b0;
      ansFire  = 1'b0;
      goFwd    = 1'b0;
      fwdAddr  = effAddr;
      lswHold_next = lswHold_reg;
      if (take) begin
         if (objBad) begin
            ansFire = 1'b1;
            ansExc  = 1'b1;
         end else if ((regAddr >= user_map_pkg::TABLE_BASE)
                   && (regAddr <= ENTRY_LAST)) begin
            ansFire = 1'b1;
            tableWe = selReq.write;
            if (!selReq.write) begin
               ansWord = table_reg[tableIdx];
            end
         end else if ((regAddr >= user_map_pkg::TABLE_BASE)
                   && (regAddr <= user_map_pkg::VALUE_RSVD)
                   && !viaSlot) begin
            ansFire = 1'b1;
         end else if (viaSlot && ((slotEntry == user_map_pkg::ENTRY_RESET)
                   || ((slotEntry >= user_map_pkg::TABLE_BASE)
                   && (slotEntry <= user_map_pkg::VALUE_RSVD)))) begin
            ansFire = 1'b1;
            ansExc  = 1'b1;
         end else if (aliasHit.hit) begin
            if (!aliasHit.legal) begin
               ansFire = 1'b1;
               ansExc  = 1'b1;
            end else if (aliasHit.fwd) begin
               goFwd   = 1'b1;
               fwdAddr = aliasHit.target;
            end else begin
               ansFire = 1'b1;
               if (effAddr == user_map_pkg::FAST_MIRROR) begin
                  ansWord = mirrorStatus;
               end
            end
         end else if (effAddr == user_map_pkg::CUR_MSW
                   || effAddr == user_map_pkg::CUR_LSW) begin
            ansFire = 1'b1;
            ansExc  = selReq.write;
            if (effAddr == user_map_pkg::CUR_MSW) begin
               ansWord      = curMsw;
               lswHold_next = avgCurrent[15:0];
            end else begin
               ansWord = lswHold_reg;
            end
         end else begin
            goFwd = 1'b1;
         end
      end
   end

   // Table storage, cleared only by reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < SLOTS; i++) begin
            table_reg[i] <= user_map_pkg::ENTRY_RESET;
         end
      end else if (tableWe) begin
         table_reg[tableIdx] <= selReq.wdata;
      end
   end

   // Sequencer next state
   always_comb begin
      state_next    = state_reg;
      servNet_next  = servNet_reg;
      curWrite_next = curWrite_reg;
      tgtReq_next   = tgtReq_reg;
      netAns_next   = '0;
      cfgAns_next   = '0;
      unique case (state_reg)
         user_map_pkg::ST_IDLE: begin
            if (take) begin
               servNet_next  = grantNet;
               curWrite_next = selReq.write;
               if (goFwd) begin
                  state_next        = user_map_pkg::ST_FWD;
                  tgtReq_next.valid = 1'b1;
                  tgtReq_next.write = selReq.write;
                  tgtReq_next.addr  = fwdAddr;
                  tgtReq_next.wdata = selReq.wdata;
               end else begin
                  state_next = user_map_pkg::ST_DONE;
               end
               if (ansFire) begin
                  netAns_next = grantNet ? {1'b1, ansExc, ansWord} : '0;
                  cfgAns_next = grantNet ? '0 : {1'b1, ansExc, ansWord};
               end
            end
         end
         user_map_pkg::ST_FWD: begin
            if (tgtAns.ack) begin
               state_next        = user_map_pkg::ST_DONE;
               tgtReq_next.valid = 1'b0;
               if (servNet_reg) begin
                  netAns_next.valid     = 1'b1;
                  netAns_next.exception = tgtAns.error;
                  netAns_next.rdata     = curWrite_reg ? 16'h0000
                                                       : tgtAns.rdata;
               end else begin
                  cfgAns_next.valid     = 1'b1;
                  cfgAns_next.exception = tgtAns.error;
                  cfgAns_next.rdata     = curWrite_reg ? 16'h0000
                                                       : tgtAns.rdata;
               end
            end
         end
         user_map_pkg::ST_DONE: begin
            state_next = user_map_pkg::ST_IDLE;
         end
         default: begin
            state_next = user_map_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg    <= user_map_pkg::ST_IDLE;
         servNet_reg  <= 1'b0;
         curWrite_reg <= 1'b0;
         tgtReq_reg   <= '0;
         netAns_reg   <= '0;
         cfgAns_reg   <= '0;
         lswHold_reg  <= user_map_pkg::WORD_ZERO;
      end else begin
         state_reg    <= state_next;
         servNet_reg  <= servNet_next;
         curWrite_reg <= curWrite_next;
         tgtReq_reg   <= tgtReq_next;
         netAns_reg   <= netAns_next;
         cfgAns_reg   <= cfgAns_next;
         lswHold_reg  <= lswHold_next;
      end
   end

   assign netAns = netAns_reg;
   assign cfgAns = cfgAns_reg;
   assign tgtReq = tgtReq_reg;

   // Checks
   a_slot_target: assert property (
      @(posedge clk) disable iff (rst)
      (take && viaSlot && goFwd && !aliasHit.hit)
      |=> tgtReq.valid && tgtReq.addr == $past(slotEntry))
      else $error("slot forwarded to wrong target");

   a_fwd_held: assert property (
      @(posedge clk) disable iff (rst)
      (tgtReq.valid && !tgtAns.ack) |=> tgtReq.valid && $stable(tgtReq.addr))
      else $error("target request dropped before acknowledge");

   a_read_return: assert property (
      @(posedge clk) disable iff (rst)
      (state_reg == user_map_pkg::ST_FWD && tgtAns.ack && !tgtAns.error
       && !curWrite_reg)
      |=> (netAns.valid || cfgAns.valid)
       && ((netAns.valid ? netAns.rdata : cfgAns.rdata)
           == $past(tgtAns.rdata)))
      else $error("slot read did not return target data");

   a_unmapped_exc: assert property (
      @(posedge clk) disable iff (rst)
      (take && viaSlot && slotEntry == user_map_pkg::ENTRY_RESET)
      |=> (netAns.exception || cfgAns.exception) && !tgtReq.valid)
      else $error("empty entry did not raise exception");

   a_alias_ctrl: assert property (
      @(posedge clk) disable iff (rst)
      (take && !objBad && !viaSlot && fastProfile
       && regAddr == user_map_pkg::FAST_CTRL)
      |=> tgtReq.valid && tgtReq.addr == user_map_pkg::PRI_CTRL)
      else $error("control alias not forwarded");

   a_alias_ocmd: assert property (
      @(posedge clk) disable iff (rst)
      (take && !objBad && !viaSlot && fastProfile && selReq.write
       && regAddr == user_map_pkg::FAST_OCMD)
      |=> tgtReq.write && tgtReq.addr == user_map_pkg::PRI_OCMD
       && tgtReq.wdata == $past(selReq.wdata))
      else $error("output command alias not forwarded");

   a_profile_off: assert property (
      @(posedge clk) disable iff (rst)
      (take && !objBad && !viaSlot && !fastProfile
       && regAddr == user_map_pkg::FAST_CTRL)
      |=> tgtReq.addr == user_map_pkg::FAST_CTRL)
      else $error("alias served outside fast profile");

   a_current_msw: assert property (
      @(posedge clk) disable iff (rst)
      (take && !selReq.write && effAddr == user_map_pkg::CUR_MSW
       && !aliasHit.hit && !objBad && !(viaSlot && slotEntry == 16'h0000))
      |=> (netAns.rdata | cfgAns.rdata) == $past(curMsw)
          && lswHold_reg == $past(avgCurrent[15:0]))
      else $error("current words not most significant first");

   a_table_kept: assert property (
      @(posedge clk) disable iff (rst)
      (!tableWe && tableIdx < 7'(SLOTS))
      |=> $stable(table_reg[tableIdx]) || $changed(tableIdx))
      else $error("table entry changed without write");

endmodule : user_map_register_indirection

/* testbench/target_model.sv */
module target_model (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Register path
   input  wire user_map_pkg::tgt_req_t tgtReq,
   output user_map_pkg::tgt_ans_t      tgtAns,
   // Answer delay in cycles
   input  wire logic [2:0]             delay
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [logic [15:0]];
   logic [2:0]  waitCnt;
   logic        done;

   // Unwritten places read a pattern of their address
   function automatic logic [15:0] peek(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : a ^ 16'hA5A5;
   endfunction : peek

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tgtAns <= '0;
         waitCnt <= 3'h0;
         done <= 1'h0;
      end else begin
         tgtAns.ack <= 1'h0;
         tgtAns.error <= 1'h0;
         // Released data toggles each cycle
         tgtAns.rdata <= ~tgtAns.rdata;
         if (tgtReq.valid !== 1'h1) begin
            waitCnt <= 3'h0;
            done <= 1'h0;
         end else if (!done && waitCnt < delay) begin
            waitCnt <= waitCnt + 3'h1;
         end else if (!done) begin
            done <= 1'h1;
            tgtAns.ack <= 1'h1;
            // Upper space is not implemented
            tgtAns.error <= tgtReq.addr >= 16'h0900;
            if (tgtReq.write && tgtReq.addr < 16'h0900) begin
               mem[tgtReq.addr] = tgtReq.wdata;
            end else if (!tgtReq.write) begin
               tgtAns.rdata <= peek(tgtReq.addr);
            end
         end
      end
   end
endmodule : target_model

/* testbench/test_user_map_register_indirection.sv */
module test_user_map_register_indirection;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk;
   logic                   rst;
   logic                   netValid;
   logic                   cfgValid;
   logic                   fastProfile;
   logic [15:0]            mirrorStatus;
   logic [31:0]            avgCurrent;
   logic [2:0]             delay;
   user_map_pkg::req_t     netReq;
   user_map_pkg::req_t     cfgReq;
   user_map_pkg::ans_t     netAns;
   user_map_pkg::ans_t     cfgAns;
   user_map_pkg::tgt_req_t tgtReq;
   user_map_pkg::tgt_ans_t tgtAns;
   int                     failures;
   int                     checked;
   int                     i;
   int                     sl [10] = '{0, 1, 2, 5, 6, 7, 50, 51, 52, 98};
   logic [15:0]            tg [10];
   logic [15:0]            vl [10];
   logic [15:0]            q;
   logic [15:0]            d;
   logic [31:0]            c;
   logic                   x;

   user_map_register_indirection u_user_map_register_indirection (
      .clk(clk), .rst(rst), .netValid(netValid), .netReq(netReq),
      .netAns(netAns), .cfgValid(cfgValid), .cfgReq(cfgReq),
      .cfgAns(cfgAns), .tgtReq(tgtReq), .tgtAns(tgtAns),
      .fastProfile(fastProfile), .mirrorStatus(mirrorStatus),
      .avgCurrent(avgCurrent));

   target_model u_target_model (
      .clk(clk), .rst(rst), .tgtReq(tgtReq), .tgtAns(tgtAns),
      .delay(delay));

   always #2 clk = ~clk;

   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   task automatic chkw(input string s, input logic [15:0] e,
                       input logic [15:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chkw

   task automatic chkf(input string s, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", s, e, g);
      end
   endtask : chkf

   // One access; m is {local port, object, write}
   task automatic go(input logic [2:0] m, input logic [15:0] a,
                     input logic [15:0] w);
      int                 n;
      user_map_pkg::ans_t r;
      @(negedge clk);
      delay = 3'($urandom % 4);
      r = '0;
      netReq = '{write: m[0], isObject: m[1], addr: a, wdata: w};
      cfgReq = netReq;
      netValid = !m[2];
      cfgValid = m[2];
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         r = m[2] ? cfgAns : netAns;
         if (r.valid === 1'h1) break;
      end
      netValid = 1'h0;
      cfgValid = 1'h0;
      q = r.rdata;
      x = r.exception;
      if (n == 40) begin
         failures++;
         $display("[FAIL] answer wait expected valid seen none");
         summarize();
      end
   endtask : go

   function automatic logic [15:0] ad(input logic o, input logic v,
                                      input int k);
      if (o) return {v ? user_map_pkg::OBJ_CLASS_VALUE
                       : user_map_pkg::OBJ_CLASS_ADDR, 8'(k + 1)};
      return (v ? user_map_pkg::VALUE_BASE : user_map_pkg::TABLE_BASE)
             + 16'(k);
   endfunction : ad

   initial begin
      c = $urandom(32'h7AD4);
      clk = 1'h0;
      rst = 1'h1;
      netValid = 1'h0;
      cfgValid = 1'h0;
      netReq = '0;
      cfgReq = '0;
      fastProfile = 1'h0;
      mirrorStatus = 16'h0000;
      avgCurrent = 32'h0000_0000;
      delay = 3'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      go(3'h0, user_map_pkg::TABLE_BASE, 16'h0000);
      chkw("table reset", user_map_pkg::ENTRY_RESET, q);
      go(3'h1, user_map_pkg::TABLE_RSVD, 16'h5A5A);
      go(3'h0, user_map_pkg::TABLE_RSVD, 16'h0000);
      chkw("table spare", user_map_pkg::WORD_ZERO, q);
      go(3'h5, user_map_pkg::VALUE_RSVD, 16'hA5A5);
      go(3'h0, user_map_pkg::VALUE_RSVD, 16'h0000);
      chkw("value spare", user_map_pkg::WORD_ZERO, q);
      // Program table from both ports, mixed addressing
      for (i = 0; i < 10; i++) begin
         tg[i] = 16'h0600 + 16'(sl[i] * 4) + 16'($urandom % 4);
         go({i[0], i[1], 1'h1}, ad(i[1], 1'h0, sl[i]), tg[i]);
         chkf("table write", 1'h0, x);
      end
      for (i = 0; i < 10; i++) begin
         go({i[0], ~i[1], 1'h0}, ad(~i[1], 1'h0, sl[i]), 16'h0000);
         chkw("table read", tg[i], q);
      end
      for (i = 0; i < 10; i++) begin
         vl[i] = 16'($urandom);
         go({i[1], i[0], 1'h1}, ad(i[0], 1'h1, sl[i]), vl[i]);
         chkw("target", vl[i], u_target_model.mem[tg[i]]);
      end
      for (i = 0; i < 10; i++) begin
         go({1'h0, ~i[0], 1'h0}, ad(~i[0], 1'h1, sl[i]), 16'h0000);
         chkw("slot", vl[i], q);
      end
      go(3'h0, user_map_pkg::VALUE_BASE + 16'h0003, 16'h0000);
      chkf("empty entry", 1'h1, x);
      go(3'h1, user_map_pkg::TABLE_BASE + 16'h0003, 16'h0F10);
      go(3'h0, user_map_pkg::VALUE_BASE + 16'h0003, 16'h0000);
      chkf("unimplemented", 1'h1, x);
      go(3'h2, {user_map_pkg::OBJ_CLASS_VALUE, 8'h65}, 16'h0000);
      chkf("bad instance", 1'h1, x);
      go(3'h2, {8'h6F, user_map_pkg::OBJ_INST_FIRST}, 16'h0000);
      chkf("bad class", 1'h1, x);
      avgCurrent = $urandom;
      c = avgCurrent;
      go(3'h0, user_map_pkg::CUR_MSW, 16'h0000);
      chkw("current high", c[31:16], q);
      avgCurrent = ~c;
      go(3'h0, user_map_pkg::CUR_LSW, 16'h0000);
      chkw("current low", c[15:0], q);
      fastProfile = 1'h1;
      mirrorStatus = 16'($urandom);
      go(3'h0, user_map_pkg::FAST_MIRROR, 16'h0000);
      chkw("mirror", mirrorStatus, q);
      go(3'h0, user_map_pkg::FAST_RSVD, 16'h0000);
      chkw("alias spare", user_map_pkg::WORD_ZERO, q);
      for (i = 0; i < 4; i++) begin
         d = 16'($urandom);
         go(3'h1, user_map_pkg::TABLE_BASE + 16'h0004,
            user_map_pkg::PRI_SYS1 + 16'(i));
         go(3'h1, user_map_pkg::VALUE_BASE + 16'h0004, d);
         go(3'h0, user_map_pkg::FAST_SYS1 + 16'(i), 16'h0000);
         chkw("status alias", d, q);
      end
      go(3'h1, user_map_pkg::FAST_OCMD, d);
      chkw("out command", d, u_target_model.mem[16'h02BC]);
      go(3'h0, user_map_pkg::FAST_OCMD, 16'h0000);
      chkf("out command read", 1'h1, x);
      go(3'h1, user_map_pkg::FAST_CTRL, ~d);
      go(3'h0, user_map_pkg::FAST_CTRL, 16'h0000);
      chkw("control", ~d, q);
      go(3'h1, user_map_pkg::FAST_AOCMD, d);
      chkw("analog", d, u_target_model.mem[16'h02C2]);
      go(3'h0, user_map_pkg::FAST_AOCMD, 16'h0000);
      chkf("analog read", 1'h1, x);
      fastProfile = 1'h0;
      go(3'h0, user_map_pkg::FAST_MIRROR, 16'h0000);
      chkf("full list", 1'h1, x);
      go(3'h0, user_map_pkg::FAST_CTRL, 16'h0000);
      chkf("full list control", 1'h1, x);
      summarize();
   end
endmodule : test_user_map_register_indirection
